// ==== include/dsac_cfg.svh ====
// Register indexes, field positions, reset values and constants of the DMA channel control.
// Assumes a word-addressed Avalon-MM slave port with a 4-bit address.
`ifndef DSAC_CFG_SVH
`define DSAC_CFG_SVH
`define DSAC_IDX_CTRL    4'h0
`define DSAC_IDX_CMD     4'h1
`define DSAC_IDX_SRC     4'h2
`define DSAC_IDX_DST     4'h3
`define DSAC_IDX_COUNT   4'h4
`define DSAC_IDX_PAT     4'h5
`define DSAC_IDX_STAT    4'h6
`define DSAC_IDX_CRC     4'h7
`define DSAC_IDX_ISTAT   4'h8
`define DSAC_IDX_ICLR    4'h9
`define DSAC_IDX_IEN     4'ha
`define DSAC_IDX_RIDX    4'hb
`define DSAC_IDX_RDATA   4'hc
`define DSAC_IDX_RAPP    4'hd
`define DSAC_IDX_RCNT    4'he
`define DSAC_CTRL_MSB    3
`define DSAC_CTRL_CHAN   2
`define DSAC_CTRL_RST    4'h0
`define DSAC_CMD_FORCE   0
`define DSAC_CMD_ABORT   1
`define DSAC_IRQ_MSB     3
`define DSAC_IRQ_RST     4'h0
`define DSAC_CRC_POLY    16'h1021
`define DSAC_CRC_INIT    16'hffff
`define DSAC_WORD_STEP   32'h00000004
`define DSAC_RES_DEPTH   5'h10
`endif

// ==== include/dsac_pkg.sv ====
// Types shared by the DMA channel control, the memory model and the bench.
// Assumes dsac_cfg.svh is included by the modules that use field positions.
package dsac_pkg;
  // Control register fields, bit 0 first from the right.
  typedef struct packed {
    logic pm;
    logic chan;
    logic susp;
    logic on;
  } dsac_ctrl_type;

  // System bus master request.
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dsac_mreq_type;

  // Word mover states.
  typedef enum logic [1:0] {ST_IDLE, ST_RD, ST_WR} dsac_state_type;
endpackage

// ==== logic/dsac_res_mem.sv ====
// Result buffer memory: sixteen words, one write port, registered read.
// Assumes the reader ignores words above the fill count.
`timescale 1ns/1ps
module dsac_res_mem (
  // Clock and reset.
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  // Write port.
  input  wire logic        i_we,
  input  wire logic [3:0]  i_waddr,
  input  wire logic [31:0] i_wdata,
  // Read port.
  input  wire logic [3:0]  i_raddr,
  output logic      [31:0] o_rdata
);
  logic [31:0] mem [0:15];

  // Store a word on each write strobe.
  always_ff @(posedge i_ref_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Read data always come out of a register.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rdata <= 32'h0;
    end else begin
      o_rdata <= mem[i_raddr];
    end
  end
endmodule // dsac_res_mem

// ==== logic/dsac_chan.sv ====
// DMA channel control: one channel, Avalon-MM registers, word mover, CRC and result buffer.
// Assumes the trigger and the bus acknowledge come from logic on the same clock.
`timescale 1ns/1ps
`include "dsac_cfg.svh"
module dsac_chan import dsac_pkg::*; (
  // Clock and reset.
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  // Avalon-MM slave.
  input  wire logic [3:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Peripheral trigger.
  input  wire logic        i_trig,
  // System bus master.
  output dsac_mreq_type    o_mreq,
  input  wire logic [31:0] i_mem_rdata,
  input  wire logic        i_mem_ack,
  // Interrupt.
  output logic             o_irq
);
  dsac_ctrl_type  ctrl_r;
  dsac_state_type st_r;
  logic [31:0] src_base_r, dst_base_r, src_ptr_r, dst_ptr_r, pattern_r, rd_mux;
  logic [7:0]  count_r, cell_r;
  logic [15:0] crc_r, word_crc;
  logic [`DSAC_IRQ_MSB:0] irq_stat_r, irq_en_r, irq_ev;
  logic [3:0]  res_idx_r;
  logic [4:0]  res_cnt_r;
  logic [31:0] mem_q, mem_wdata;
  logic        evt_r, wcommit, w_ctrl, w_cmd, force_cmd, abort_cmd, chan_off_wr;
  logic        run_ok, trig_ok, abandon, off_drop, svc_done, pm_hit, last, keep_ptrs;
  logic        hw_app, sw_app, res_full;

  // Address match used by every write strobe.
  function automatic logic hit(input logic [3:0] a, input logic [3:0] idx);
    return a == idx;
  endfunction

  // CRC-16 over one 32-bit word, most significant bit first.
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [31:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ({r[14:0], 1'b0} ^ `DSAC_CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, then the access takes effect.
  assign wcommit   = i_avs_write && !o_avs_waitrequest;
  assign w_ctrl    = wcommit && hit(i_avs_address, `DSAC_IDX_CTRL);
  assign w_cmd     = wcommit && hit(i_avs_address, `DSAC_IDX_CMD);
  assign force_cmd = w_cmd && i_avs_writedata[`DSAC_CMD_FORCE];
  assign abort_cmd = w_cmd && i_avs_writedata[`DSAC_CMD_ABORT];
  assign chan_off_wr = w_ctrl && ctrl_r.chan && !i_avs_writedata[`DSAC_CTRL_CHAN];

  // Waitrequest drops for the single cycle in which the request is completed.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= !((i_avs_read || i_avs_write) && o_avs_waitrequest);
    end
  end

  // Read data are latched in the wait cycle and stand through the answer cycle.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_avs_readdata <= 32'h0;
    end else if (i_avs_read && o_avs_waitrequest) begin
      o_avs_readdata <= rd_mux;
    end
  end

  // Read decode; unmapped and write-only indexes read as zero.
  always_comb begin
    rd_mux = 32'h0;
    if (i_avs_address == `DSAC_IDX_CTRL) begin
      rd_mux = {28'h0, ctrl_r};
    end else if (i_avs_address == `DSAC_IDX_SRC) begin
      rd_mux = src_ptr_r;
    end else if (i_avs_address == `DSAC_IDX_DST) begin
      rd_mux = dst_ptr_r;
    end else if (i_avs_address == `DSAC_IDX_COUNT) begin
      rd_mux = {24'h0, count_r};
    end else if (i_avs_address == `DSAC_IDX_PAT) begin
      rd_mux = pattern_r;
    end else if (i_avs_address == `DSAC_IDX_STAT) begin
      rd_mux = {16'h0, cell_r, 6'h0, evt_r, st_r != ST_IDLE};
    end else if (i_avs_address == `DSAC_IDX_CRC) begin
      rd_mux = {16'h0, crc_r};
    end else if (i_avs_address == `DSAC_IDX_ISTAT) begin
      rd_mux = {28'h0, irq_stat_r};
    end else if (i_avs_address == `DSAC_IDX_IEN) begin
      rd_mux = {28'h0, irq_en_r};
    end else if (i_avs_address == `DSAC_IDX_RIDX) begin
      rd_mux = {28'h0, res_idx_r};
    end else if (i_avs_address == `DSAC_IDX_RDATA) begin
      rd_mux = ({1'b0, res_idx_r} < res_cnt_r) ? mem_q : 32'h0;
    end else if (i_avs_address == `DSAC_IDX_RCNT) begin
      rd_mux = {27'h0, res_cnt_r};
    end
  end

  // Software-written configuration.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ctrl_r     <= dsac_ctrl_type'(`DSAC_CTRL_RST);
      src_base_r <= 32'h0;
      dst_base_r <= 32'h0;
      count_r    <= 8'h0;
      pattern_r  <= 32'h0;
      irq_en_r   <= `DSAC_IRQ_RST;
      res_idx_r  <= 4'h0;
    end else begin
      if (w_ctrl) ctrl_r <= dsac_ctrl_type'(i_avs_writedata[`DSAC_CTRL_MSB:0]);
      if (wcommit && hit(i_avs_address, `DSAC_IDX_SRC)) src_base_r <= i_avs_writedata;
      if (wcommit && hit(i_avs_address, `DSAC_IDX_DST)) dst_base_r <= i_avs_writedata;
      if (wcommit && hit(i_avs_address, `DSAC_IDX_COUNT)) count_r <= i_avs_writedata[7:0];
      if (wcommit && hit(i_avs_address, `DSAC_IDX_PAT)) pattern_r <= i_avs_writedata;
      if (wcommit && hit(i_avs_address, `DSAC_IDX_IEN)) begin
        irq_en_r <= i_avs_writedata[`DSAC_IRQ_MSB:0];
      end
      if (wcommit && hit(i_avs_address, `DSAC_IDX_RIDX)) res_idx_r <= i_avs_writedata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Channel event and word mover.
  assign run_ok   = ctrl_r.on && !ctrl_r.susp && ctrl_r.chan && (cell_r < count_r);
  assign trig_ok  = i_trig && ctrl_r.on && !ctrl_r.susp && ctrl_r.chan;
  assign off_drop = (st_r != ST_IDLE) && !ctrl_r.on;
  assign abandon  = off_drop || ((st_r != ST_IDLE) && abort_cmd);
  assign svc_done = (st_r == ST_WR) && i_mem_ack && !abandon;
  assign pm_hit   = ctrl_r.pm && (o_mreq.wdata == pattern_r);
  assign last     = svc_done && ((8'(cell_r + 8'h01) == count_r) || pm_hit);
  assign word_crc = crc_step(crc_r, o_mreq.wdata);
  assign keep_ptrs = !ctrl_r.chan && (cell_r != 8'h0);

  // Pending event: a new trigger or force wins over any clear in the same cycle.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      evt_r <= 1'b0;
    end else if (trig_ok || force_cmd) begin
      evt_r <= 1'b1;
    end else if (abort_cmd) begin
      evt_r <= 1'b0;
    end else if (svc_done && !chan_off_wr) begin
      evt_r <= 1'b0;
    end
  end

  // Read a word at the source pointer, then write it at the destination pointer.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_r   <= ST_IDLE;
      o_mreq <= '0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (evt_r && run_ok && !abort_cmd) begin
            o_mreq.rd   <= 1'b1;
            o_mreq.addr <= src_ptr_r;
            st_r        <= ST_RD;
          end
        end
        ST_RD: begin
          if (abandon) begin
            o_mreq.rd <= 1'b0;
            st_r      <= ST_IDLE;
          end else if (i_mem_ack) begin
            o_mreq.rd    <= 1'b0;
            o_mreq.wr    <= 1'b1;
            o_mreq.addr  <= dst_ptr_r;
            o_mreq.wdata <= i_mem_rdata;
            st_r         <= ST_WR;
          end
        end
        default: begin
          if (abandon || i_mem_ack) begin
            o_mreq.wr <= 1'b0;
            st_r      <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Pointers advance per word and return to the bases at block end or abort, except an abort with the channel bit clear partway through a block.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      src_ptr_r <= 32'h0;
      dst_ptr_r <= 32'h0;
      cell_r    <= 8'h0;
    end else if ((abort_cmd && !keep_ptrs) || last) begin
      src_ptr_r <= src_base_r;
      dst_ptr_r <= dst_base_r;
      cell_r    <= 8'h0;
    end else if (svc_done) begin
      src_ptr_r <= src_ptr_r + `DSAC_WORD_STEP;
      dst_ptr_r <= dst_ptr_r + `DSAC_WORD_STEP;
      cell_r    <= 8'(cell_r + 8'h01);
    end else if (wcommit && hit(i_avs_address, `DSAC_IDX_SRC)) begin
      src_ptr_r <= i_avs_writedata;
    end else if (wcommit && hit(i_avs_address, `DSAC_IDX_DST)) begin
      dst_ptr_r <= i_avs_writedata;
    end
  end

  // Running CRC over moved words, restarted per block.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      crc_r <= `DSAC_CRC_INIT;
    end else if (last || (abort_cmd && !keep_ptrs)) begin
      crc_r <= `DSAC_CRC_INIT;
    end else if (svc_done) begin
      crc_r <= word_crc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Result buffer; hardware append has priority over a software append.
  assign res_full  = (res_cnt_r == `DSAC_RES_DEPTH);
  assign hw_app    = last && !pm_hit && !res_full;
  assign sw_app    = wcommit && hit(i_avs_address, `DSAC_IDX_RAPP) && !hw_app && !res_full;
  assign mem_wdata = hw_app ? {16'h0, word_crc} : i_avs_writedata;

  // Fill count; a write to its index empties the buffer unless a hardware append lands in the same cycle.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      res_cnt_r <= 5'h0;
    end else if (hw_app || sw_app) begin
      res_cnt_r <= 5'(res_cnt_r + 5'h01);
    end else if (wcommit && hit(i_avs_address, `DSAC_IDX_RCNT)) begin
      res_cnt_r <= 5'h0;
    end
  end

  dsac_res_mem u_res_mem (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_we      (hw_app || sw_app),
    .i_waddr   (res_cnt_r[3:0]),
    .i_wdata   (mem_wdata),
    .i_raddr   (res_idx_r),
    .o_rdata   (mem_q)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt events: block done, match end, abort, dropped bus cycle.
  assign irq_ev = {off_drop, abort_cmd, last && pm_hit, last};

  // Sticky status; a new event wins over a clear in the same cycle.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      irq_stat_r <= `DSAC_IRQ_RST;
      o_irq      <= 1'b0;
    end else begin
      if (wcommit && hit(i_avs_address, `DSAC_IDX_ICLR)) begin
        irq_stat_r <= (irq_stat_r & ~i_avs_writedata[`DSAC_IRQ_MSB:0]) | irq_ev;
      end else begin
        irq_stat_r <= irq_stat_r | irq_ev;
      end
      o_irq <= |(irq_stat_r & irq_en_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  a_trig_lost: assert property ((ctrl_r.susp && !force_cmd && !evt_r) |=> !evt_r)
    else $error("trigger captured while suspended");
  a_abort_keep: assert property ((abort_cmd && keep_ptrs && !svc_done) |=>
    ($stable(src_ptr_r) && $stable(dst_ptr_r) && $stable(cell_r)))
    else $error("pointers changed on abort while suspended");
  a_abort_reset: assert property ((abort_cmd && !keep_ptrs) |=>
    (cell_r == 8'h0 && src_ptr_r == $past(src_base_r)))
    else $error("pointers not reset on abort");
  a_stale_event: assert property ((svc_done && chan_off_wr && !abort_cmd) |=> evt_r)
    else $error("event cleared on suspend collision");
  a_serve_clear: assert property ((svc_done && !chan_off_wr && !trig_ok && !force_cmd)
    |=> !evt_r)
    else $error("event not cleared after service");
  a_force_start: assert property ((force_cmd && st_r == ST_IDLE && run_ok && !w_ctrl &&
    !abort_cmd) |-> ##[1:2] o_mreq.rd)
    else $error("forced request did not start a read");
  a_reenable_go: assert property ((st_r == ST_IDLE && evt_r && run_ok && !abort_cmd)
    |=> (o_mreq.rd && o_mreq.addr == $past(src_ptr_r)))
    else $error("pending event did not start at once");
  a_off_abandon: assert property (off_drop |=> (st_r == ST_IDLE && !o_mreq.rd &&
    !o_mreq.wr && irq_stat_r[`DSAC_IRQ_MSB]))
    else $error("bus cycle not dropped on disable");
  a_pm_drop: assert property ((last && pm_hit && !sw_app) |=> $stable(res_cnt_r))
    else $error("match-ended block appended a result");

  c_block_done: cover property (last && !pm_hit);
  c_stale_event: cover property (svc_done && chan_off_wr);
  c_abort_keep: cover property (abort_cmd && keep_ptrs);
  c_force_move: cover property (force_cmd ##[1:4] svc_done);
endmodule // dsac_chan

// ==== bench/dsac_mem_model.sv ====
// System bus memory model: sixteen words, acknowledge after a set number of wait cycles.
// Assumes one rd or wr request at a time, held until its acknowledge.
`timescale 1ns/1ps
module dsac_mem_model import dsac_pkg::*; (
  // Clock and reset.
  input  wire logic          i_ref_clk,
  input  wire logic          i_rst,
  // Bus request from the engine.
  input  wire dsac_mreq_type i_mreq,
  output logic        [31:0] o_rdata,
  output logic               o_ack,
  // Wait cycles before acknowledge.
  input  wire logic   [7:0]  i_dly
);
  logic [31:0] mem [0:15];
  logic [7:0]  cnt_r;
  int          wr_cnt;

  // Known contents so moved words can be told apart.
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 32'h5a000000 + i * 32'h01010101;
    wr_cnt = 0;
  end

  // Acknowledge after the delay; a dropped request restarts the count.
  // Read data only stands with the acknowledge and toggles otherwise.
  // A plain always is used because the initial block also fills the memory.
  always @(posedge i_ref_clk) begin
    if (i_rst || o_ack || !(i_mreq.rd || i_mreq.wr)) begin
      cnt_r   <= 8'h00;
      o_ack   <= 1'b0;
      o_rdata <= ~o_rdata;
    end else if (cnt_r >= i_dly) begin
      o_ack   <= 1'b1;
      o_rdata <= mem[i_mreq.addr[5:2]];
      if (i_mreq.wr) begin
        mem[i_mreq.addr[5:2]] <= i_mreq.wdata;
        wr_cnt <= wr_cnt + 1;
      end
    end else begin
      cnt_r   <= cnt_r + 8'h01;
      o_rdata <= ~o_rdata;
    end
  end
endmodule // dsac_mem_model

// ==== bench/dsac_tb.sv ====
// Self-checking bench for the DMA channel control through its register port.
// Assumes the memory model as far side and a trigger driven here.
`timescale 1ns/1ps
`include "dsac_cfg.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb import dsac_pkg::*;;
  logic          i_ref_clk = 1'b0;
  logic          i_rst = 1'b1;
  logic [3:0]    i_avs_address = 4'h0;
  logic          i_avs_read = 1'b0;
  logic          i_avs_write = 1'b0;
  logic [31:0]   i_avs_writedata = 32'h0;
  logic [31:0]   o_avs_readdata;
  logic          o_avs_waitrequest;
  logic          i_trig = 1'b0;
  dsac_mreq_type o_mreq;
  logic [31:0]   mem_rdata;
  logic          mem_ack;
  logic          o_irq;
  logic [7:0]    dly = 8'h01;
  logic [31:0]   rd;
  logic [31:0]   cnt0;
  logic [15:0]   crc_e;
  int            fails = 0;
  int            num_checks = 0;
  int            cyc = 0;

  always #20 i_ref_clk = ~i_ref_clk;

  dsac_chan dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest), .i_trig(i_trig),
    .o_mreq(o_mreq), .i_mem_rdata(mem_rdata), .i_mem_ack(mem_ack), .o_irq(o_irq));
  dsac_mem_model mdl (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_mreq(o_mreq),
    .o_rdata(mem_rdata), .o_ack(mem_ack), .i_dly(dly));

  ////////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Cuts a hang short.
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      complete_run();
    end
  end

  // One Avalon access, held until waitrequest is sampled low.
  task automatic avs(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_avs_address   <= a;
    i_avs_writedata <= d;
    i_avs_read      <= !w;
    i_avs_write     <= w;
    for (int i = 0; i < 50; i++) begin
      @(posedge i_ref_clk);
      if (o_avs_waitrequest === 1'b0) break;
    end
    rd = o_avs_readdata;
    i_avs_read  <= 1'b0;
    i_avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    avs(1'b1, a, d);
  endtask

  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    avs(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  // One trigger pulse, then a bounded wait for the memory write and settling.
  task automatic trig_move();
    cnt0 = mdl.wr_cnt;
    @(posedge i_ref_clk);
    i_trig <= 1'b1;
    @(posedge i_ref_clk);
    i_trig <= 1'b0;
    for (int i = 0; i < 100 && mdl.wr_cnt == cnt0; i++) @(posedge i_ref_clk);
    repeat (4) @(posedge i_ref_clk);
  endtask

  // Reference CRC over one word, most significant bit first.
  function automatic logic [15:0] crc_w(input logic [15:0] c, input logic [31:0] d);
    for (int i = 31; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? `DSAC_CRC_POLY : 16'h0);
    return c;
  endfunction

  task automatic end_test(input string s);
    $display("test %s finished, mismatches so far %0d", s, fails);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    rchk(`DSAC_IDX_CTRL, 32'h0);
    rchk(`DSAC_IDX_CRC, 32'h0000ffff);
    rchk(4'hf, 32'h0);
    end_test("reset");
    // Plain two-word block from trigger to interrupt.
    wr(`DSAC_IDX_SRC, 32'h0);
    wr(`DSAC_IDX_DST, 32'h20);
    wr(`DSAC_IDX_COUNT, 32'h2);
    wr(`DSAC_IDX_IEN, 32'hf);
    wr(`DSAC_IDX_CTRL, 32'h5);
    crc_e = crc_w(crc_w(`DSAC_CRC_INIT, mdl.mem[0]), mdl.mem[1]);
    trig_move();
    `CHK(mdl.mem[8], mdl.mem[0])
    trig_move();
    `CHK(mdl.mem[9], mdl.mem[1])
    rchk(`DSAC_IDX_ISTAT, 32'h1);
    `CHK(o_irq, 1'b1)
    rchk(`DSAC_IDX_RCNT, 32'h1);
    wr(`DSAC_IDX_RIDX, 32'h0);
    rchk(`DSAC_IDX_RDATA, {16'h0, crc_e});
    rchk(`DSAC_IDX_SRC, 32'h0);
    wr(`DSAC_IDX_ICLR, 32'hf);
    // Status clears at the commit edge and the interrupt register follows one edge later.
    repeat (2) @(posedge i_ref_clk);
    `CHK(o_irq, 1'b0)
    end_test("block");
    // Trigger while suspended is lost; software forces the move after resume.
    wr(`DSAC_IDX_CTRL, 32'h7);
    trig_move();
    wr(`DSAC_IDX_CTRL, 32'h5);
    repeat (20) @(posedge i_ref_clk);
    `CHK(mdl.wr_cnt, cnt0)
    rchk(`DSAC_IDX_STAT, 32'h0);
    cnt0 = mdl.wr_cnt;
    wr(`DSAC_IDX_CMD, 32'h1);
    repeat (20) @(posedge i_ref_clk);
    `CHK(mdl.wr_cnt, cnt0 + 1)
    rchk(`DSAC_IDX_STAT, 32'h100);
    end_test("suspend");
    // Abort after a partway suspend keeps pointers; abort first resets them.
    wr(`DSAC_IDX_CTRL, 32'h1);
    wr(`DSAC_IDX_CMD, 32'h2);
    rchk(`DSAC_IDX_STAT, 32'h100);
    rchk(`DSAC_IDX_SRC, 32'h4);
    rchk(`DSAC_IDX_DST, 32'h24);
    rchk(`DSAC_IDX_ISTAT, 32'h4);
    wr(`DSAC_IDX_CTRL, 32'h5);
    wr(`DSAC_IDX_CMD, 32'h2);
    wr(`DSAC_IDX_CTRL, 32'h1);
    rchk(`DSAC_IDX_STAT, 32'h0);
    rchk(`DSAC_IDX_SRC, 32'h0);
    end_test("abort");
    // Pattern-match end appends no CRC; software appends the CRC register, already back at its initial value.
    wr(`DSAC_IDX_ICLR, 32'hf);
    wr(`DSAC_IDX_PAT, mdl.mem[0]);
    wr(`DSAC_IDX_COUNT, 32'h4);
    wr(`DSAC_IDX_CTRL, 32'hd);
    trig_move();
    rchk(`DSAC_IDX_ISTAT, 32'h3);
    rchk(`DSAC_IDX_RCNT, 32'h1);
    avs(1'b0, `DSAC_IDX_CRC, 32'h0);
    wr(`DSAC_IDX_RAPP, rd);
    rchk(`DSAC_IDX_RCNT, 32'h2);
    wr(`DSAC_IDX_RIDX, 32'h1);
    rchk(`DSAC_IDX_RDATA, 32'h0000ffff);
    end_test("pattern");
    // Engine off mid-cycle drops the bus cycle and flags it.
    wr(`DSAC_IDX_ICLR, 32'hf);
    wr(`DSAC_IDX_CTRL, 32'h5);
    dly <= 8'h28;
    @(posedge i_ref_clk);
    i_trig <= 1'b1;
    @(posedge i_ref_clk);
    i_trig <= 1'b0;
    for (int i = 0; i < 20 && o_mreq.rd !== 1'b1; i++) @(posedge i_ref_clk);
    wr(`DSAC_IDX_CTRL, 32'h0);
    repeat (3) @(posedge i_ref_clk);
    `CHK(o_mreq.rd, 1'b0)
    rchk(`DSAC_IDX_ISTAT, 32'h8);
    `CHK(o_irq, 1'b1)
    end_test("engine_off");
    complete_run();
  end
endmodule // tb
